//--- hlef_pkg.sv
// What this block does
// - End-of-reception flag, bit 3, sets when a complete message is received.
// - End-of-reception flag also sets when the receive buffer becomes full.
// - Flags reset to 0; a status read returns and clears every flag.
// - Checksum-error flag, bit 2, sets on a bad frame check sequence.
// - Abort flag, bit 1, sets on seven consecutive ones on the link.
// - Idle flag, bit 0, sets whenever the flag octet 0x7E is seen.
// - Enable bit 6, reset 0, gates start-of-transmission onto the interrupt.
// - Enable bit 5, reset 0, gates start-of-reception onto the interrupt.
// - Enable bit 4, reset 0, gates end-of-transmission onto the interrupt.
// - Enable bit 3, reset 0, gates end-of-reception onto the interrupt.
// - Status bits 6..4 sticky begin/end flags; bit 7 shows message kind.
// - Enable bits 2..0, reset 0, gate checksum, abort and idle events.
package hlef_pkg;
	// Register byte addresses
	localparam logic [31:0] STATUS_OFS = 32'h0000_0000;
	localparam logic [31:0] ENABLE_OFS = 32'h0000_0004;
	// Status and enable field positions
	localparam int unsigned BIT_IDLE = 0;
	localparam int unsigned BIT_ABORT = 1;
	localparam int unsigned BIT_FCS = 2;
	localparam int unsigned BIT_RX_END = 3;
	localparam int unsigned BIT_TX_END = 4;
	localparam int unsigned BIT_RX_BEGIN = 5;
	localparam int unsigned BIT_TX_BEGIN = 6;
	localparam int unsigned BIT_KIND = 7;
	localparam int unsigned NUM_EVT = 7;
	// Reset values
	localparam logic [NUM_EVT-1:0] FLAG_RST = 7'h00;
	localparam logic [NUM_EVT-1:0] ENABLE_RST = 7'h00;
	localparam logic [2:0] ONES_RST = 3'h0;
	localparam logic [7:0] SHIFT_RST = 8'h00;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	// Link pattern constants
	localparam logic [2:0] ABORT_ONES = 3'h7;
	localparam logic [2:0] ONE_INC = 3'h1;
	localparam logic [7:0] FLAG_OCTET = 8'h7E;
	// Bus encodings
	localparam logic HRESP_OKAY = 1'b0;

	// Event pulses from the HDLC engines, one cycle each
	typedef struct packed {
		logic rx_msg_end;
		logic rx_buf_full;
		logic rx_fcs_bad;
		logic tx_begin;
		logic rx_begin;
		logic tx_end;
	} hlef_evt_s;

	// Register requests decoded from the bus
	typedef struct packed {
		logic rd;
		logic [31:0] rd_addr;
		logic wr;
		logic [31:0] wr_addr;
		logic [31:0] wdata;
	} hlef_req_s;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_WDATA = 2'b10
	} hlef_bus_state_e;
endpackage

//--- hlef_flag_bank.sv
`timescale 1ns/1ps
module hlef_flag_bank (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [hlef_pkg::NUM_EVT-1:0] set_i,
	input wire logic [hlef_pkg::NUM_EVT-1:0] clr_i,
	output logic [hlef_pkg::NUM_EVT-1:0] flag_o
);
	typedef struct packed {
		logic [hlef_pkg::NUM_EVT-1:0] flag;
	} hlef_bank_s;

	hlef_bank_s st;
	hlef_bank_s next_st;
	logic [hlef_pkg::NUM_EVT-1:0] next_flag;

	// Sticky per bit; a set in the clearing cycle wins so no event is lost
	genvar gi;
	generate
		for (gi = 0; gi < hlef_pkg::NUM_EVT; gi++)
		begin : g_flag
			assign next_flag[gi] = set_i[gi] | (st.flag[gi] & ~clr_i[gi]);
		end
	endgenerate

	// Next state
	always_comb
	begin
		next_st = st;
		next_st.flag = next_flag;
	end

	// State register
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			st.flag <= hlef_pkg::FLAG_RST;
		else
			st <= next_st;
	end

	assign flag_o = st.flag;
endmodule // hlef_flag_bank

//--- hlef_ahb_slave.sv
`timescale 1ns/1ps
module hlef_ahb_slave (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	input wire logic [31:0] rd_data_i,
	output hlef_pkg::hlef_req_s req_o,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);
	typedef struct packed {
		hlef_pkg::hlef_bus_state_e phase;
		logic [31:0] wr_addr;
		logic [31:0] hrdata;
	} hlef_slv_s;

	hlef_slv_s st;
	hlef_slv_s next_st;
	logic accept;

	// NONSEQ and SEQ both carry a transfer; size is not checked
	assign accept = hsel_i & hready_i & htrans_i[1];

	// Reads act at the address phase so read data sits in a flop
	always_comb
	begin
		next_st = st;
		req_o.rd = accept & ~hwrite_i;
		req_o.rd_addr = haddr_i;
		req_o.wr = (st.phase == hlef_pkg::BUS_WDATA);
		req_o.wr_addr = st.wr_addr;
		req_o.wdata = hwdata_i;
		if (req_o.rd)
			next_st.hrdata = rd_data_i;
		case (st.phase)
			hlef_pkg::BUS_IDLE:
			begin
				if (accept & hwrite_i)
				begin
					next_st.phase = hlef_pkg::BUS_WDATA;
					next_st.wr_addr = haddr_i;
				end
			end
			hlef_pkg::BUS_WDATA:
			begin
				// Write data phase lasts one cycle; a new write may follow
				if (accept & hwrite_i)
					next_st.wr_addr = haddr_i;
				else
					next_st.phase = hlef_pkg::BUS_IDLE;
			end
			default:
				next_st.phase = hlef_pkg::BUS_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			st.phase <= hlef_pkg::BUS_IDLE;
			st.wr_addr <= hlef_pkg::WORD_ZERO;
			st.hrdata <= hlef_pkg::WORD_ZERO;
		end
		else
			st <= next_st;
	end

	// Zero wait states, always OKAY
	assign hrdata_o = st.hrdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = hlef_pkg::HRESP_OKAY;
	logic unused_size;
	assign unused_size = ^hsize_i;
endmodule // hlef_ahb_slave

//--- hlef_link_event_flags.sv
// Added by the designer: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module hlef_link_event_flags (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] hwdata_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire hlef_pkg::hlef_evt_s evt_i,
	input wire logic rx_message_kind_i,
	input wire logic rx_bit_en_i,
	input wire logic rx_bit_i,
	output logic irq_o
);
	typedef struct packed {
		logic [hlef_pkg::NUM_EVT-1:0] enable;
		logic kind;
		logic [2:0] ones_cnt;
		logic [7:0] shift;
	} hlef_top_s;

	hlef_top_s st;
	hlef_top_s next_st;
	hlef_pkg::hlef_req_s req;
	logic [hlef_pkg::NUM_EVT-1:0] flags;
	logic [hlef_pkg::NUM_EVT-1:0] set_vec;
	logic [hlef_pkg::NUM_EVT-1:0] clr_vec;
	logic [31:0] rd_data;
	logic [7:0] shift_in;
	logic abort_hit;
	logic octet_hit;
	logic rd_status;
	logic wr_status;
	logic wr_enable;
	logic [hlef_pkg::NUM_EVT-1:0] masked;

	hlef_ahb_slave u_slave (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.hsel_i(hsel_i),
		.haddr_i(haddr_i),
		.htrans_i(htrans_i),
		.hwrite_i(hwrite_i),
		.hsize_i(hsize_i),
		.hready_i(hready_i),
		.hwdata_i(hwdata_i),
		.rd_data_i(rd_data),
		.req_o(req),
		.hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o),
		.hresp_o(hresp_o)
	);

	hlef_flag_bank u_flags (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.set_i(set_vec),
		.clr_i(clr_vec),
		.flag_o(flags)
	);

	// Link bit stream, sent LSB first, shifts in from the top
	assign shift_in = {rx_bit_i, st.shift[7:1]};
	// Seventh one in a row; a longer run raises no second event
	assign abort_hit = rx_bit_en_i & rx_bit_i
		& (st.ones_cnt == hlef_pkg::ABORT_ONES - hlef_pkg::ONE_INC);
	assign octet_hit = rx_bit_en_i
		& (shift_in == hlef_pkg::FLAG_OCTET);

	// Event sources onto flag positions
	always_comb
	begin
		set_vec = hlef_pkg::FLAG_RST;
		set_vec[hlef_pkg::BIT_RX_END] = evt_i.rx_msg_end
			| evt_i.rx_buf_full;
		set_vec[hlef_pkg::BIT_FCS] = evt_i.rx_fcs_bad;
		set_vec[hlef_pkg::BIT_ABORT] = abort_hit;
		set_vec[hlef_pkg::BIT_IDLE] = octet_hit;
		set_vec[hlef_pkg::BIT_TX_BEGIN] = evt_i.tx_begin;
		set_vec[hlef_pkg::BIT_RX_BEGIN] = evt_i.rx_begin;
		set_vec[hlef_pkg::BIT_TX_END] = evt_i.tx_end;
	end

	// Register decode
	assign rd_status = req.rd & (req.rd_addr == hlef_pkg::STATUS_OFS);
	assign wr_status = req.wr & (req.wr_addr == hlef_pkg::STATUS_OFS);
	assign wr_enable = req.wr & (req.wr_addr == hlef_pkg::ENABLE_OFS);

	// A read clears every flag it returns, not the kind bit; a written one clears as well
	always_comb
	begin
		clr_vec = hlef_pkg::FLAG_RST;
		if (rd_status)
			clr_vec = ~hlef_pkg::FLAG_RST;
		if (wr_status)
			clr_vec = clr_vec | req.wdata[hlef_pkg::NUM_EVT-1:0];
	end

	// Read mux; unmapped addresses read zero
	always_comb
	begin
		rd_data = hlef_pkg::WORD_ZERO;
		if (req.rd_addr == hlef_pkg::STATUS_OFS)
		begin
			rd_data[hlef_pkg::NUM_EVT-1:0] = flags;
			rd_data[hlef_pkg::BIT_KIND] = st.kind;
		end
		else if (req.rd_addr == hlef_pkg::ENABLE_OFS)
			rd_data[hlef_pkg::NUM_EVT-1:0] = st.enable;
	end

	// Enable register, run-length counter and octet shifter
	always_comb
	begin
		next_st = st;
		next_st.kind = rx_message_kind_i;
		if (wr_enable)
			// Only bits 6..0 exist, bit 7 is dropped
			next_st.enable = req.wdata[hlef_pkg::NUM_EVT-1:0];
		if (rx_bit_en_i)
		begin
			next_st.shift = shift_in;
			if (!rx_bit_i)
				next_st.ones_cnt = hlef_pkg::ONES_RST;
			else if (st.ones_cnt != hlef_pkg::ABORT_ONES)
				next_st.ones_cnt = st.ones_cnt + hlef_pkg::ONE_INC;
		end
	end

	// State register
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			st.enable <= hlef_pkg::ENABLE_RST;
			st.kind <= 1'b0;
			st.ones_cnt <= hlef_pkg::ONES_RST;
			st.shift <= hlef_pkg::SHIFT_RST;
		end
		else
			st <= next_st;
	end

	// Each flag reaches the request only through its own enable bit
	genvar gi;
	generate
		for (gi = 0; gi < hlef_pkg::NUM_EVT; gi++)
		begin : g_mask
			assign masked[gi] = flags[gi]
				& st.enable[gi];
		end
	endgenerate

	// Level request from flops; flags record events even when masked
	assign irq_o = |masked;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_rx_end_set: assert property (evt_i.rx_msg_end |=>
		flags[hlef_pkg::BIT_RX_END])
		else $error("end of reception did not set its flag");
	a_buf_full_set: assert property (evt_i.rx_buf_full |=>
		flags[hlef_pkg::BIT_RX_END])
		else $error("buffer full did not set end of reception");
	a_read_clears: assert property ((rd_status && !(|set_vec))
		|=> (flags == hlef_pkg::FLAG_RST)
		&& (hrdata_o[hlef_pkg::NUM_EVT-1:0] == $past(flags)))
		else $error("status read did not return and clear flags");
	a_fcs_set: assert property (evt_i.rx_fcs_bad |=>
		flags[hlef_pkg::BIT_FCS])
		else $error("checksum error did not set its flag");
	a_abort_seven: assert property ((rx_bit_en_i && rx_bit_i) [*7]
		|=> flags[hlef_pkg::BIT_ABORT] || $past(rd_status))
		else $error("seven ones did not set abort");
	a_abort_cause: assert property ($rose(flags[hlef_pkg::BIT_ABORT])
		|-> $past(abort_hit))
		else $error("abort flag rose without seven ones");
	a_octet_set: assert property ((rx_bit_en_i
		&& {rx_bit_i, st.shift[7:1]} == hlef_pkg::FLAG_OCTET)
		|=> flags[hlef_pkg::BIT_IDLE])
		else $error("flag octet did not set idle");
	a_tx_begin_irq: assert property ((evt_i.tx_begin
		&& st.enable[hlef_pkg::BIT_TX_BEGIN] && !wr_enable) |=> irq_o)
		else $error("enabled start of transmission gave no interrupt");
	a_rx_begin_irq: assert property ((evt_i.rx_begin
		&& st.enable[hlef_pkg::BIT_RX_BEGIN] && !wr_enable) |=> irq_o)
		else $error("enabled start of reception gave no interrupt");
	a_tx_end_irq: assert property ((evt_i.tx_end
		&& st.enable[hlef_pkg::BIT_TX_END] && !wr_enable) |=> irq_o)
		else $error("enabled end of transmission gave no interrupt");
	a_rx_end_irq: assert property ((evt_i.rx_msg_end
		&& st.enable[hlef_pkg::BIT_RX_END] && !wr_enable) |=> irq_o)
		else $error("enabled end of reception gave no interrupt");
	a_kind_read: assert property (rd_status |=>
		hrdata_o[hlef_pkg::BIT_KIND] == $past(st.kind))
		else $error("message kind not shown in status bit 7");
	a_fcs_irq: assert property ((evt_i.rx_fcs_bad
		&& st.enable[hlef_pkg::BIT_FCS] && !wr_enable) |=> irq_o)
		else $error("enabled checksum error gave no interrupt");
	a_mask_blocks: assert property (
		(st.enable == hlef_pkg::ENABLE_RST) |-> !irq_o)
		else $error("interrupt raised with all events masked");
	a_flags_hold: assert property ((set_vec == hlef_pkg::FLAG_RST)
		&& (clr_vec == hlef_pkg::FLAG_RST)
		|=> (flags == $past(flags)))
		else $error("flags changed with no event and no clear");
	a_enable_rsvd: assert property ((req.rd
		&& req.rd_addr == hlef_pkg::ENABLE_OFS)
		|=> hrdata_o[7] == 1'b0)
		else $error("reserved enable bit read as one");

	// Transmit flags and start of reception record whatever the mask
	a_tx_begin_set: assert property (evt_i.tx_begin |=>
		flags[hlef_pkg::BIT_TX_BEGIN])
		else $error("start of transmission did not set its flag");
	a_rx_begin_set: assert property (evt_i.rx_begin |=>
		flags[hlef_pkg::BIT_RX_BEGIN])
		else $error("start of reception did not set its flag");
	a_tx_end_set: assert property (evt_i.tx_end |=>
		flags[hlef_pkg::BIT_TX_END])
		else $error("end of transmission did not set its flag");

	// Link events and buffer full onto the request; a write to the enable in the same
	// cycle may mask the event, so such cycles are left out
	a_abort_irq: assert property ((abort_hit
		&& st.enable[hlef_pkg::BIT_ABORT] && !wr_enable)
		|=> irq_o)
		else $error("enabled abort gave no interrupt");
	a_idle_irq: assert property ((octet_hit
		&& st.enable[hlef_pkg::BIT_IDLE] && !wr_enable)
		|=> irq_o)
		else $error("enabled flag octet gave no interrupt");
	a_buf_full_irq: assert property ((evt_i.rx_buf_full
		&& st.enable[hlef_pkg::BIT_RX_END] && !wr_enable)
		|=> irq_o)
		else $error("enabled buffer full gave no interrupt");
	a_abort_once: assert property (abort_hit |=> !abort_hit)
		else $error("one long run of ones aborted twice");
	a_zero_breaks: assert property ((rx_bit_en_i && !rx_bit_i)
		|=> !abort_hit)
		else $error("abort counted across a zero bit");

	// Sticky set, clear by read or by written ones; the set wins so an
	// event in the clearing cycle shows at the next read
	a_set_sticky: assert property (|set_vec
		|=> ((flags & $past(set_vec)) == $past(set_vec)))
		else $error("event lost or held back by its mask");
	a_wr_clear: assert property ((wr_status && !(|set_vec))
		|=> ((flags & $past(req.wdata[hlef_pkg::NUM_EVT-1:0]))
		== hlef_pkg::FLAG_RST))
		else $error("written one did not clear its flag");
	a_irq_drop: assert property ((rd_status && !(|set_vec))
		|=> !irq_o)
		else $error("interrupt stayed up after the status read");
	a_rdata_hold: assert property (!req.rd |=> $stable(hrdata_o))
		else $error("read data changed with no read");
	a_enable_write: assert property (wr_enable |=>
		st.enable == $past(req.wdata[hlef_pkg::NUM_EVT-1:0]))
		else $error("enable write lost bits 6 to 0");
	a_enable_hold: assert property (!wr_enable |=>
		$stable(st.enable))
		else $error("enable register changed with no write");
	a_enable_read: assert property ((req.rd
		&& req.rd_addr == hlef_pkg::ENABLE_OFS)
		|=> hrdata_o[hlef_pkg::NUM_EVT-1:0] == $past(st.enable))
		else $error("enable read did not return the enables");
	a_upper_zero: assert property (rd_status |=>
		hrdata_o[31:8] == 24'h00_0000)
		else $error("status read showed bits above the byte");

	// Per flag: it stays until a clear reaches it, and a clear with no
	// event in the same cycle always takes it down
	genvar gk;
	generate
		for (gk = 0; gk < hlef_pkg::NUM_EVT; gk++)
		begin : g_flag_chk
			a_flag_stays: assert property (flags[gk]
				&& !clr_vec[gk]
				|=> flags[gk])
				else $error("flag dropped without a clear");
			a_flag_drops: assert property (clr_vec[gk]
				&& !set_vec[gk]
				|=> !flags[gk])
				else $error("flag survived its clear");
		end
	endgenerate

	c_abort_seen: cover property (abort_hit ##1 irq_o);
	c_read_clear: cover property (irq_o ##1 rd_status ##1 !irq_o);
	c_set_in_clear: cover property (rd_status && (|set_vec));
	c_enable_write: cover property (wr_enable ##1 (st.enable != 7'h00));
	c_write_clear: cover property (wr_status ##1 (flags == hlef_pkg::FLAG_RST));
endmodule // hlef_link_event_flags

//--- hlef_hdlc_model.sv
`timescale 1ns/1ps
// Stands in for the transmit and receive HDLC engines on the event side
module hlef_hdlc_model (
	input wire logic ref_clk_i,
	output hlef_pkg::hlef_evt_s evt_o,
	output logic kind_o,
	output logic bit_en_o,
	output logic bit_o
);
	initial
	begin
		evt_o = '0;
		kind_o = 1'b0;
		bit_en_o = 1'b0;
		bit_o = 1'b0;
	end

	// One-cycle event pulse; index follows the struct, lsb is tx_end
	task automatic pulse(input int k);
		@(posedge ref_clk_i);
		evt_o <= hlef_pkg::hlef_evt_s'(6'h01 << k);
		@(posedge ref_clk_i);
		evt_o <= '0;
	endtask

	// Link bits go out lsb first, one per cycle
	task automatic send(input logic [15:0] pat, input int n);
		for (int i = 0; i < n; i++)
		begin
			@(posedge ref_clk_i);
			bit_en_o <= 1'b1;
			bit_o <= pat[i];
		end
		@(posedge ref_clk_i);
		bit_en_o <= 1'b0;
		// Idle line shows the inverse so a stale bit is never mistaken
		bit_o <= ~pat[n-1];
	endtask
endmodule // hlef_hdlc_model

//--- hdlc_link_event_flags_tb.sv
`timescale 1ns/1ps
module hdlc_link_event_flags_tb;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic hsel_i = 1'b0;
	logic [31:0] haddr_i = 32'h0000_0000;
	logic [1:0] htrans_i = 2'h0;
	logic hwrite_i = 1'b0;
	logic [31:0] hwdata_i = 32'h0000_0000;
	logic [31:0] hrdata_o;
	logic hreadyout_o;
	logic hresp_o;
	logic irq_o;
	logic kind;
	logic bit_en;
	logic link_bit;
	logic [31:0] rd;
	hlef_pkg::hlef_evt_s evt;
	int failures = 0;
	int comparisons = 0;
	int evt_bit [6] = '{4, 5, 6, 2, 3, 3};

	initial
	begin
		forever #2 ref_clk_i = ~ref_clk_i;
	end

	hlef_link_event_flags dut_u (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hready_i(hreadyout_o), .hwdata_i(hwdata_i),
		.hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.evt_i(evt), .rx_message_kind_i(kind), .rx_bit_en_i(bit_en),
		.rx_bit_i(link_bit), .irq_o(irq_o)
	);

	hlef_hdlc_model model_u (
		.ref_clk_i(ref_clk_i), .evt_o(evt), .kind_o(kind),
		.bit_en_o(bit_en), .bit_o(link_bit)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic end_of_test();
		$display("comparisons %0d, failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Wait on hready with a bound; a hang counts against the run
	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge ref_clk_i);
			n++;
		end
		while (hreadyout_o !== 1'b1 && n < 50);
		if (n >= 50)
			check(32'h0000_0001, 32'h0000_0000);
	endtask

	// One single word transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		@(posedge ref_clk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		hwrite_i <= w;
		htrans_i <= 2'h2;
		wait_ready();
		htrans_i <= 2'h0;
		hwdata_i <= wd;
		wait_ready();
		r = hrdata_o;
		check({31'h0, hresp_o}, {31'h0, hlef_pkg::HRESP_OKAY});
	endtask

	task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000, rd);
		check(rd, exp);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, rd);
	endtask

	initial
	begin
		#20000;
		check(32'h0000_0001, 32'h0000_0000);
		end_of_test();
	end

	initial
	begin
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		// Reset values and the reserved enable bit
		rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0000);
		rd_chk(hlef_pkg::ENABLE_OFS, 32'h0000_0000);
		check({31'h0, irq_o}, 32'h0000_0000);
		wr(hlef_pkg::ENABLE_OFS, 32'h0000_00FF);
		rd_chk(hlef_pkg::ENABLE_OFS, 32'h0000_007F);
		rd_chk(32'h0000_0008, 32'h0000_0000);
		$display("test reset and enable done");
		// Each event masked by its own enable with all other enables set, then unmasked alone
		for (int k = 0; k < 6; k++)
		begin
			wr(hlef_pkg::ENABLE_OFS, 32'h7F & ~(32'h1 << evt_bit[k]));
			model_u.pulse(k);
			#1;
			check({31'h0, irq_o}, 32'h0000_0000);
			rd_chk(hlef_pkg::STATUS_OFS, 32'h1 << evt_bit[k]);
			rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0000);
			wr(hlef_pkg::ENABLE_OFS, 32'h1 << evt_bit[k]);
			model_u.pulse(k);
			#1;
			check({31'h0, irq_o}, 32'h0000_0001);
			rd_chk(hlef_pkg::STATUS_OFS, 32'h1 << evt_bit[k]);
			check({31'h0, irq_o}, 32'h0000_0000);
		end
		$display("test event flags done");
		// Flag octet holds only six ones; seven ones abort; eighth is quiet
		wr(hlef_pkg::ENABLE_OFS, 32'h0000_0003);
		model_u.send(16'h007E, 8);
		#1;
		check({31'h0, irq_o}, 32'h0000_0001);
		rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0001);
		model_u.send(16'h007F, 7);
		rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0002);
		model_u.send(16'h0001, 1);
		rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0000);
		model_u.send(16'h7E7E, 16);
		rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0001);
		// Written ones clear only their own flags
		model_u.pulse(0);
		model_u.pulse(2);
		wr(hlef_pkg::STATUS_OFS, 32'h0000_0040);
		rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0010);
		$display("test link patterns done");
		// Message kind shows in bit 7 and is not cleared by the read
		@(posedge ref_clk_i);
		model_u.kind_o <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0080);
		rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0080);
		$display("test message kind done");
		// Reset in mid-run clears flags and enables; kind follows its input
		wr(hlef_pkg::ENABLE_OFS, 32'h0000_007F);
		model_u.pulse(5);
		#1;
		check({31'h0, irq_o}, 32'h0000_0001);
		sys_rst_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		rd_chk(hlef_pkg::STATUS_OFS, 32'h0000_0080);
		rd_chk(hlef_pkg::ENABLE_OFS, 32'h0000_0000);
		check({31'h0, irq_o}, 32'h0000_0000);
		$display("test mid-run reset done");
		end_of_test();
	end
endmodule // hdlc_link_event_flags_tb
